// file: ch2_pin_output.sv
// Compare output pin of channel 2 register A
module ch2_pin_output
  import timer_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  // Control
  input wire logic [PIN_CTRL_W-1:0] ctrl,
  input wire logic ctrl_load,
  input wire logic match,
  // Pin
  output logic pin_out,
  output logic pin_oe
);
  pin_mode_type mode;

  assign mode = pin_mode_type'(ctrl[1:0]);

  // Capture setting leaves the pin undriven
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pin_oe <= 1'b0;
    else if (clear)
      pin_oe <= 1'b0;
    else
      pin_oe <= !ctrl[PIN_CAPTURE_BIT] && mode != PIN_DISABLED;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pin_out <= 1'b0;
    else if (clear)
      pin_out <= 1'b0;
    else if (ctrl_load)
      pin_out <= ctrl[PIN_INIT_BIT];
    else if (match && !ctrl[PIN_CAPTURE_BIT])
    begin
      unique case (mode)
        PIN_DISABLED: pin_out <= pin_out;
        PIN_DRIVE_0: pin_out <= 1'b0;
        PIN_DRIVE_1: pin_out <= 1'b1;
        PIN_TOGGLE: pin_out <= !pin_out;
      endcase
    end
  end
endmodule

// file: channel_counter_unit.sv
// 16-bit channel counter with wrap detection and direction flag
module channel_counter_unit
  import timer_irq_pkg::*;
#(
  parameter bit PHASE_OK = 1'b0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  // Count control
  input wire logic count_en,
  input wire logic count_down,
  input wire logic phase_mode,
  // State and events
  output logic [CNT_W-1:0] cnt,
  output logic up_dir,
  output logic overflow_evt,
  output logic underflow_evt,
  output logic moved
);
  logic down;

  // Down counting only exists in phase counting channels
  assign down = PHASE_OK && phase_mode && count_down;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt <= CNT_ZERO;
    else if (clear)
      cnt <= CNT_ZERO;
    else if (count_en)
      cnt <= down ? cnt - 16'h0001 : cnt + 16'h0001;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      up_dir <= 1'b1;
    else if (clear)
      up_dir <= 1'b1;
    else if (count_en)
      up_dir <= !down;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      overflow_evt <= 1'b0;
      underflow_evt <= 1'b0;
      moved <= 1'b0;
    end
    else
    begin
      overflow_evt <= !clear && count_en && !down && cnt == CNT_MAX;
      underflow_evt <= !clear && count_en && down && cnt == CNT_ZERO;
      moved <= !clear && count_en;
    end
  end
endmodule

// file: irq_sink_model.sv
// Interrupt controller and A/D trigger model facing the gating block
module irq_sink_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Requests from the timer
  input wire logic irq,
  input wire logic adc_start,
  // Observed activity
  output int adc_count,
  output int irq_rise_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic irq_reg;

  // A start request is one pulse, so each high cycle is one conversion
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      adc_count <= 0;
    else if (adc_start === 1'b1)
      adc_count <= adc_count + 1;
  end

  // Level request: only a rising edge is a new interrupt
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_reg <= 1'b0;
      irq_rise_count <= 0;
    end
    else
    begin
      irq_reg <= irq;
      if (irq === 1'b1 && irq_reg === 1'b0)
        irq_rise_count <= irq_rise_count + 1;
    end
  end
endmodule

// file: testbench.sv
// Self-checking testbench of the timer interrupt enable gating block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_irq_pkg::*;
  logic mclk;
  logic resetn;
  logic hw_standby;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  logic [CH_COUNT-1:0] count_en;
  logic [CH_COUNT-1:0] count_down;
  logic [CH_COUNT-1:0] phase_mode;
  logic [CH_COUNT-1:0] a_irq;
  logic [CH_COUNT-1:0] b_irq;
  logic c_irq;
  logic d_irq;
  logic [CH_COUNT-1:0] ov_irq;
  logic [CH_COUNT-1:0] un_irq;
  logic irq;
  logic adc_start;
  logic pin_out;
  logic pin_oe;
  int adc_count;
  int irq_rises;
  int errors = 0;
  int check_count = 0;

  timer_irq_enable_gating uut (.MCLK(mclk), .RESETN(resetn),
    .HW_STANDBY(hw_standby), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .COUNT_EN(count_en), .COUNT_DOWN(count_down),
    .PHASE_MODE(phase_mode), .MATCH_A_IRQ(a_irq), .MATCH_B_IRQ(b_irq),
    .MATCH_C_IRQ(c_irq), .MATCH_D_IRQ(d_irq), .OVERFLOW_IRQ(ov_irq),
    .UNDERFLOW_IRQ(un_irq), .IRQ(irq), .ADC_START(adc_start),
    .PIN_A2_OUT(pin_out), .PIN_A2_OE(pin_oe));

  irq_sink_model model (.clk(mclk), .resetn(resetn), .irq(irq),
    .adc_start(adc_start), .adc_count(adc_count),
    .irq_rise_count(irq_rises));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog sized well above the few hundred cycles the tests need
  initial
  begin
    #(20000 * 100);
    errors++;
    report_and_stop();
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Readable bits are the writable mask plus the fixed one
  function automatic logic [15:0] exp_ier(input int ch, input logic [7:0] v);
    logic [7:0] m;
    m = (ch == 0) ? IER_WMASK_CH0 : IER_WMASK_CH12;
    return {8'h00, (v & m) | IER_FIXED_ONE};
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic settle;
    @(posedge mclk);
    #1;
  endtask

  // One count step; flags land two edges later, so wait three
  task automatic step(input logic [2:0] en, input logic [2:0] dn);
    @(posedge mclk);
    count_en <= en;
    count_down <= dn;
    @(posedge mclk);
    count_en <= 3'b000;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  initial
  begin
    int ch;
    logic [7:0] v;
    int cnt2;
    logic [1:0] lvl;
    resetn = 1'b0;
    hw_standby = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    count_en = '0;
    count_down = '0;
    phase_mode = '0;
    void'($urandom(32));
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    phase_mode <= 3'b010;
    for (int i = 0; i < 3; i++)
    begin
      rd_chk(8'(ADDR_IER_BASE + i), 16'h0040);
      rd_chk(8'(ADDR_STAT_BASE + i), 16'h00C0);
    end
    // Read data stand for one cycle only
    settle();
    check(rdata, 16'h0000);
    // Corners first (all ones, all zeros), then random patterns
    for (int i = 0; i < 16; i++)
    begin
      ch = $urandom_range(2, 0);
      v = 8'($urandom);
      if (i < 6)
      begin
        ch = i % 3;
        v = (i < 3) ? 8'hFF : 8'h00;
      end
      wr_reg(8'(ADDR_IER_BASE + ch), {8'h00, v});
      rd_chk(8'(ADDR_IER_BASE + ch), exp_ier(ch, v));
    end
    wr_reg(8'h0B, 16'hFFFF);
    rd_chk(8'h0B, 16'h0000);
    wr_reg(8'(ADDR_IER_BASE), 16'h00FF);
    @(posedge mclk);
    hw_standby <= 1'b1;
    repeat (8) @(posedge mclk);
    hw_standby <= 1'b0;
    repeat (8) @(posedge mclk);
    for (int i = 0; i < 3; i++)
      rd_chk(8'(ADDR_IER_BASE + i), 16'h0040);
    // Channel 1: underflow, overflow, then match A without A/D start
    wr_reg(8'(ADDR_IER_BASE + 1), 16'h0031);
    wr_reg(8'h14, 16'h0001);
    step(3'b010, 3'b010);
    check({15'h0, un_irq[1]}, 16'h0001);
    check({15'h0, ov_irq[1]}, 16'h0000);
    check({15'h0, b_irq[1]}, 16'h0000);
    step(3'b010, 3'b000);
    check({15'h0, ov_irq[1]}, 16'h0001);
    step(3'b010, 3'b000);
    check({15'h0, a_irq[1]}, 16'h0001);
    check(16'(adc_count), 16'h0000);
    rd_chk(8'(ADDR_STAT_BASE + 1), 16'h00F3);
    // Channel 0: all four matches with A/D start enabled
    wr_reg(8'(ADDR_IER_BASE), 16'h008F);
    for (int k = 0; k < 4; k++)
      wr_reg(8'(ADDR_CMP_BASE + k), 16'(k + 1));
    for (int k = 0; k < 4; k++)
      step(3'b001, 3'b000);
    check({12'h0, d_irq, c_irq, b_irq[0], a_irq[0]}, 16'h000F);
    check({15'h0, un_irq[0]}, 16'h0000);
    check(16'(adc_count), 16'h0001);
    wr_reg(8'(ADDR_IER_BASE), 16'h0000);
    settle();
    check({12'h0, d_irq, c_irq, b_irq[0], a_irq[0]}, 16'h0000);
    wr_reg(8'(ADDR_IER_BASE), 16'h000F);
    settle();
    check({12'h0, d_irq, c_irq, b_irq[0], a_irq[0]}, 16'h000F);
    // Clearing: ones ignored, a write without a fresh read clears nothing
    rd_chk(8'(ADDR_STAT_BASE), 16'h00CF);
    wr_reg(8'(ADDR_STAT_BASE), 16'h00FF);
    wr_reg(8'(ADDR_STAT_BASE), 16'h0000);
    rd_chk(8'(ADDR_STAT_BASE), 16'h00CF);
    wr_reg(8'(ADDR_STAT_BASE), 16'h00C1);
    rd_chk(8'(ADDR_STAT_BASE), 16'h00C1);
    check({14'h0, b_irq[0], a_irq[0]}, 16'h0001);
    // Summary interrupt: masked, unmasked, cleared
    check({15'h0, irq}, 16'h0000);
    wr_reg(ADDR_INT_MASK, 16'h0001);
    settle();
    check({15'h0, irq}, 16'h0001);
    wr_reg(ADDR_INT_STAT, 16'h0007);
    settle();
    check({15'h0, irq}, 16'h0000);
    check(16'(irq_rises), 16'h0001);
    // Channel 2 pin: initial level one, then each mode at a match
    cnt2 = 0;
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(ADDR_PIN_CTRL, 16'(4 + m));
      repeat (3) settle();
      check({15'h0, pin_oe}, {15'h0, m != 0});
      if (m != 0)
        check({15'h0, pin_out}, 16'h0001);
      wr_reg(8'(ADDR_CMP_BASE + 8), 16'(cnt2 + 1));
      step(3'b100, 3'b000);
      cnt2++;
      lvl = 2'(m);
      if (m != 0)
        check({15'h0, pin_out}, {15'h0, lvl == 2'd2});
    end
    check(16'(adc_count), 16'h0001);
    // Channel 2 matched with its enables off: no match A, overflow or underflow request may show
    check({13'h0, a_irq[2], ov_irq[2], un_irq[2]}, 16'h0000);
    report_and_stop();
  end
endmodule

// file: timer_irq_enable_gating.sv
// Interrupt enable gating of a three-channel 16-bit pulse timer
//
// Local design decisions: the strobed register port and the register offsets.
module timer_irq_enable_gating
  import timer_irq_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // Hardware standby pin, asynchronous
  input wire logic HW_STANDBY,
  // Register port
  input wire logic [timer_irq_pkg::ADDR_W-1:0] ADDR,
  input wire logic [timer_irq_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [timer_irq_pkg::DATA_W-1:0] RDATA,
  // Count control from logic on the same clock
  input wire logic [timer_irq_pkg::CH_COUNT-1:0] COUNT_EN,
  input wire logic [timer_irq_pkg::CH_COUNT-1:0] COUNT_DOWN,
  input wire logic [timer_irq_pkg::CH_COUNT-1:0] PHASE_MODE,
  // Interrupt requests per channel
  output logic [timer_irq_pkg::CH_COUNT-1:0] MATCH_A_IRQ,
  output logic [timer_irq_pkg::CH_COUNT-1:0] MATCH_B_IRQ,
  output logic MATCH_C_IRQ,
  output logic MATCH_D_IRQ,
  output logic [timer_irq_pkg::CH_COUNT-1:0] OVERFLOW_IRQ,
  output logic [timer_irq_pkg::CH_COUNT-1:0] UNDERFLOW_IRQ,
  // Summary interrupt and A/D trigger
  output logic IRQ,
  output logic ADC_START,
  // Channel 2 compare pin
  output logic PIN_A2_OUT,
  output logic PIN_A2_OE
);
  import timer_irq_pkg::*;

  function automatic logic [7:0] ier_wmask(input int ch);
    ier_wmask = (ch == 0) ? IER_WMASK_CH0 : IER_WMASK_CH12;
  endfunction

  function automatic logic [5:0] flag_valid(input int ch);
    flag_valid = (ch == 0) ? FLAG_VALID_CH0 : FLAG_VALID_CH12;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b,
                               input int idx);
    hit = a == b + 8'(idx);
  endfunction

  logic standby_s1, standby_s2, standby_s3;
  logic standby_reg;
  logic [7:0] channel_irq_enable_reg [CH_COUNT];
  logic [5:0] flag_reg [CH_COUNT];
  logic [5:0] seen_reg [CH_COUNT];
  logic [5:0] evt [CH_COUNT];
  logic [CNT_W-1:0] cmp_reg [CMP_COUNT];
  logic [CNT_W-1:0] cnt [CH_COUNT];
  logic [CH_COUNT-1:0] up_dir, ovf_evt, unf_evt, moved;
  logic [PIN_CTRL_W-1:0] pin_ctrl_reg;
  logic [2:0] int_stat_reg, int_mask_reg, chan_evt;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic adc_start_reg;
  logic [REG_W-1:0] fixed_bits;

  // Standby pin: three stages, a change counts once stages 2 and 3 agree
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      standby_s1 <= 1'b0;
      standby_s2 <= 1'b0;
      standby_s3 <= 1'b0;
    end
    else
    begin
      standby_s1 <= HW_STANDBY;
      standby_s2 <= standby_s1;
      standby_s3 <= standby_s2;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      standby_reg <= 1'b0;
    else if (standby_s2 == standby_s3)
      standby_reg <= standby_s3;
  end

  // Counters; only channels 1 and 2 can phase count
  for (genvar g = 0; g < CH_COUNT; g++)
  begin : gen_cnt
    channel_counter_unit #(.PHASE_OK(g != 0)) u_cnt (
      .clk(MCLK),
      .resetn(RESETN),
      .clear(standby_reg),
      .count_en(COUNT_EN[g]),
      .count_down(COUNT_DOWN[g]),
      .phase_mode(PHASE_MODE[g]),
      .cnt(cnt[g]),
      .up_dir(up_dir[g]),
      .overflow_evt(ovf_evt[g]),
      .underflow_evt(unf_evt[g]),
      .moved(moved[g])
    );
  end

  // Events; compare is checked once per counter step so a stopped counter
  // does not keep setting the flag
  always_comb
  begin
    for (int c = 0; c < CH_COUNT; c++)
    begin
      evt[c] = FLAG_RESET;
      evt[c][BIT_OVER] = ovf_evt[c];
      evt[c][BIT_UNDER] = unf_evt[c];
      evt[c][BIT_A] = moved[c] && cnt[c] == cmp_reg[c*CMP_PER_CH];
      evt[c][BIT_B] = moved[c] && cnt[c] == cmp_reg[c*CMP_PER_CH+1];
      evt[c][BIT_C] = moved[c] && cnt[c] == cmp_reg[c*CMP_PER_CH+2];
      evt[c][BIT_D] = moved[c] && cnt[c] == cmp_reg[c*CMP_PER_CH+3];
      evt[c] = evt[c] & flag_valid(c);
      chan_evt[c] = |evt[c];
    end
  end

  // Enable registers: fixed bit 6, reserved bits held at zero
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int c = 0; c < CH_COUNT; c++)
        channel_irq_enable_reg[c] <= IER_RESET;
    end
    else if (standby_reg)
    begin
      for (int c = 0; c < CH_COUNT; c++)
        channel_irq_enable_reg[c] <= IER_RESET;
    end
    else if (WR)
    begin
      for (int c = 0; c < CH_COUNT; c++)
        if (hit(ADDR, ADDR_IER_BASE, c))
          channel_irq_enable_reg[c] <= (WDATA[7:0] & ier_wmask(c))
            | IER_FIXED_ONE;
    end
  end

  // Read-as-one tracking for the zero-write clear
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int c = 0; c < CH_COUNT; c++)
        seen_reg[c] <= FLAG_RESET;
    end
    else
    begin
      for (int c = 0; c < CH_COUNT; c++)
        if (standby_reg)
          seen_reg[c] <= FLAG_RESET;
        else if (RD && hit(ADDR, ADDR_STAT_BASE, c))
          seen_reg[c] <= flag_reg[c];
        else if (WR && hit(ADDR, ADDR_STAT_BASE, c))
          seen_reg[c] <= FLAG_RESET;
    end
  end

  // Status flags: a new event wins over a clear in the same cycle
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int c = 0; c < CH_COUNT; c++)
        flag_reg[c] <= FLAG_RESET;
    end
    else
    begin
      for (int c = 0; c < CH_COUNT; c++)
        if (standby_reg)
          flag_reg[c] <= FLAG_RESET;
        else if (WR && hit(ADDR, ADDR_STAT_BASE, c))
          flag_reg[c] <= (flag_reg[c] & ~(seen_reg[c] & ~WDATA[5:0]))
            | evt[c];
        else
          flag_reg[c] <= flag_reg[c] | evt[c];
    end
  end

  // Compare registers
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < CMP_COUNT; i++)
        cmp_reg[i] <= CMP_RESET;
    end
    else
    begin
      for (int i = 0; i < CMP_COUNT; i++)
        if (standby_reg)
          cmp_reg[i] <= CMP_RESET;
        else if (WR && hit(ADDR, ADDR_CMP_BASE, i))
          cmp_reg[i] <= WDATA;
    end
  end

  // Channel 2 pin control
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      pin_ctrl_reg <= PIN_CTRL_RESET;
    else if (standby_reg)
      pin_ctrl_reg <= PIN_CTRL_RESET;
    else if (WR && ADDR == ADDR_PIN_CTRL)
      pin_ctrl_reg <= WDATA[PIN_CTRL_W-1:0];
  end

  ch2_pin_output u_pin (
    .clk(MCLK),
    .resetn(RESETN),
    .clear(standby_reg),
    .ctrl(pin_ctrl_reg),
    .ctrl_load(WR && ADDR == ADDR_PIN_CTRL),
    .match(evt[2][BIT_A]),
    .pin_out(PIN_A2_OUT),
    .pin_oe(PIN_A2_OE)
  );

  // Summary interrupt: sticky per channel, write one to clear, set wins
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      int_stat_reg <= SUM_RESET;
    else if (standby_reg)
      int_stat_reg <= SUM_RESET;
    else if (WR && ADDR == ADDR_INT_STAT)
      int_stat_reg <= (int_stat_reg & ~WDATA[2:0]) | chan_evt;
    else
      int_stat_reg <= int_stat_reg | chan_evt;
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      int_mask_reg <= SUM_RESET;
    else if (standby_reg)
      int_mask_reg <= SUM_RESET;
    else if (WR && ADDR == ADDR_INT_MASK)
      int_mask_reg <= WDATA[2:0];
  end

  assign IRQ = |(int_stat_reg & int_mask_reg);

  // A/D start pulse, one cycle after a gated match A
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      adc_start_reg <= 1'b0;
    else
    begin
      adc_start_reg <= 1'b0;
      for (int c = 0; c < CH_COUNT; c++)
        if (evt[c][BIT_A] && channel_irq_enable_reg[c][BIT_ADC])
          adc_start_reg <= 1'b1;
    end
  end

  assign ADC_START = adc_start_reg;

  // Requests follow flag and enable as levels
  always_comb
  begin
    for (int c = 0; c < CH_COUNT; c++)
    begin
      MATCH_A_IRQ[c] = flag_reg[c][BIT_A]
        && channel_irq_enable_reg[c][BIT_A];
      MATCH_B_IRQ[c] = flag_reg[c][BIT_B]
        && channel_irq_enable_reg[c][BIT_B];
      OVERFLOW_IRQ[c] = flag_reg[c][BIT_OVER]
        && channel_irq_enable_reg[c][BIT_OVER];
      UNDERFLOW_IRQ[c] = flag_reg[c][BIT_UNDER]
        && channel_irq_enable_reg[c][BIT_UNDER];
    end
  end

  assign MATCH_C_IRQ = flag_reg[0][BIT_C]
    && channel_irq_enable_reg[0][BIT_C];
  assign MATCH_D_IRQ = flag_reg[0][BIT_D]
    && channel_irq_enable_reg[0][BIT_D];

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_next = '0;
    fixed_bits = '0;
    for (int c = 0; c < CH_COUNT; c++)
    begin
      if (hit(ADDR, ADDR_IER_BASE, c))
        rdata_next = {8'h00, channel_irq_enable_reg[c] | IER_FIXED_ONE};
      if (hit(ADDR, ADDR_STAT_BASE, c))
      begin
        fixed_bits = (c == 0) ? STATUS_FIXED_CH0
          : STATUS_FIXED_CH12 | {up_dir[c], 7'h00};
        rdata_next = {8'h00, fixed_bits | {2'b00, flag_reg[c]}};
      end
      if (hit(ADDR, ADDR_CNT_BASE, c))
        rdata_next = cnt[c];
    end
    for (int i = 0; i < CMP_COUNT; i++)
      if (hit(ADDR, ADDR_CMP_BASE, i))
        rdata_next = cmp_reg[i];
    if (ADDR == ADDR_PIN_CTRL)
      rdata_next = {12'h000, pin_ctrl_reg};
    if (ADDR == ADDR_INT_STAT)
      rdata_next = {13'h0000, int_stat_reg};
    if (ADDR == ADDR_INT_MASK)
      rdata_next = {13'h0000, int_mask_reg};
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      rdata_reg <= '0;
    else
      rdata_reg <= RD ? rdata_next : '0;
  end

  assign RDATA = rdata_reg;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);

  ier_standby_a: assert property (standby_reg |=>
    channel_irq_enable_reg[1] == IER_RESET)
    else $error("enable register not reloaded in standby");
  fixed_one_a: assert property (RD && hit(ADDR, ADDR_IER_BASE, 2)
    |=> RDATA[BIT_FIXED])
    else $error("enable bit 6 read as zero");
  ch0_bit5_a: assert property (!channel_irq_enable_reg[0][BIT_UNDER])
    else $error("channel 0 bit 5 set");
  ch1_reserved_a: assert property (channel_irq_enable_reg[1][3:2] == 2'b00
    && !flag_reg[1][BIT_C])
    else $error("channel 1 reserved bits set");
  adc_gate_a: assert property (evt[1][BIT_A]
    && channel_irq_enable_reg[1][BIT_ADC] |=> ADC_START)
    else $error("A/D start lost");
  adc_quiet_a: assert property (ADC_START |->
    $past(|(evt[0][BIT_A] | evt[1][BIT_A] | evt[2][BIT_A])))
    else $error("A/D start without match");
  wrap_flag_a: assert property (!standby_reg && COUNT_EN[0]
    && !(WR && ADDR == ADDR_STAT_BASE) && cnt[0] == CNT_MAX
    |=> ##1 flag_reg[0][BIT_OVER])
    else $error("overflow flag not set on wrap");
  clear_needs_read_a: assert property (flag_reg[0][BIT_A] && !seen_reg[0][BIT_A]
    && !standby_reg |=> flag_reg[0][BIT_A])
    else $error("flag cleared without prior read");
  hold_irq_a: assert property (OVERFLOW_IRQ[2] && !standby_reg
    && !(WR && hit(ADDR, ADDR_IER_BASE, 2))
    && !(WR && hit(ADDR, ADDR_STAT_BASE, 2)) |=> OVERFLOW_IRQ[2])
    else $error("overflow request dropped early");
  match_set_a: assert property (moved[1] && cnt[1] == cmp_reg[CMP_PER_CH]
    && !standby_reg |=> flag_reg[1][BIT_A])
    else $error("match A flag not set");
  underflow_a: assert property (unf_evt[2] && !standby_reg
    |=> flag_reg[2][BIT_UNDER])
    else $error("underflow flag not set");
  pin_drive_a: assert property (!standby_reg && pin_ctrl_reg == 4'h2
    && evt[2][BIT_A] && !WR |=> PIN_A2_OUT && PIN_A2_OE)
    else $error("pin not driven high on match");

  overflow_irq_c: cover property (OVERFLOW_IRQ[0]);
  underflow_irq_c: cover property (UNDERFLOW_IRQ[1]);
  adc_start_c: cover property (ADC_START);
  pin_toggle_c: cover property (PIN_A2_OE && $changed(PIN_A2_OUT));
endmodule

// file: timer_irq_pkg.sv
// Constants and types shared by the timer interrupt enable block
package timer_irq_pkg;
  localparam int CH_COUNT = 3;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int REG_W = 8;
  localparam int FLAG_W = 6;
  localparam int CMP_PER_CH = 4;
  localparam int CMP_COUNT = 12;
  localparam int PIN_CTRL_W = 4;
  // Enable register layout
  localparam logic [7:0] IER_RESET = 8'h40;
  localparam logic [7:0] IER_FIXED_ONE = 8'h40;
  localparam logic [7:0] IER_WMASK_CH0 = 8'h9F;
  localparam logic [7:0] IER_WMASK_CH12 = 8'hB3;
  localparam int BIT_ADC = 7;
  localparam int BIT_UNDER = 5;
  localparam int BIT_OVER = 4;
  localparam int BIT_D = 3;
  localparam int BIT_C = 2;
  localparam int BIT_B = 1;
  localparam int BIT_A = 0;
  localparam int BIT_DIR = 7;
  localparam int BIT_FIXED = 6;
  // Status register layout
  localparam logic [7:0] STATUS_FIXED_CH0 = 8'hC0;
  localparam logic [7:0] STATUS_FIXED_CH12 = 8'h40;
  localparam logic [5:0] FLAG_VALID_CH0 = 6'h1F;
  localparam logic [5:0] FLAG_VALID_CH12 = 6'h33;
  localparam logic [5:0] FLAG_RESET = 6'h00;
  // Register map
  localparam logic [7:0] ADDR_IER_BASE = 8'h00;
  localparam logic [7:0] ADDR_STAT_BASE = 8'h03;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h06;
  localparam logic [7:0] ADDR_INT_STAT = 8'h07;
  localparam logic [7:0] ADDR_INT_MASK = 8'h08;
  localparam logic [7:0] ADDR_CNT_BASE = 8'h0C;
  localparam logic [7:0] ADDR_CMP_BASE = 8'h10;
  // Counter and pin control
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'hFFFF;
  localparam logic [3:0] PIN_CTRL_RESET = 4'h0;
  localparam int PIN_INIT_BIT = 2;
  localparam int PIN_CAPTURE_BIT = 3;
  localparam logic [2:0] SUM_RESET = 3'h0;
  typedef enum logic [1:0] {PIN_DISABLED, PIN_DRIVE_0, PIN_DRIVE_1,
    PIN_TOGGLE} pin_mode_type;
endpackage
